/* src/alfb_pkg.sv */
// Constants shared by the auxiliary LED fade/blink controller.
// Assumes a 125 MHz bus clock and 8-bit registers on a 32-bit bus.
`default_nettype none
package alfb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MAIN_CONTROL   = 8'h00;
  localparam logic [7:0] IDX_AUX_ENABLE     = 8'h11;
  localparam logic [7:0] IDX_BLINK_TIMERS   = 8'h12;
  localparam logic [7:0] IDX_FADE_TIMES     = 8'h13;
  localparam logic [7:0] IDX_LED_ONE_SINK   = 8'h14;
  localparam logic [7:0] IDX_LED_TWO_SINK   = 8'h15;
  localparam logic [7:0] IDX_LED_THREE_SINK = 8'h16;
  localparam logic [7:0] IDX_AUX_STATUS     = 8'h30;
  // Field positions
  localparam int MAIN_MASTER_BIT = 7;
  localparam int AUX_SQUARE_BIT  = 3;
  localparam int BLINK_ON_LSB    = 0;  // 2 bits, shared on time
  localparam int BLINK_OFF_LSB   = 2;  // 2 bits per LED from here
  localparam int FADE_IN_LSB     = 0;  // 4 bits
  localparam int FADE_OUT_LSB    = 4;  // 4 bits
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Ramp full scale; 256 makes the current product exact at full level
  localparam logic [8:0] LEVEL_FULL = 9'h100;
  // Time bases
  localparam int CLK_PERIOD_NS   = 8;
  localparam int FADE_TICK_NS    = 1000000;    // 1 ms per fade step unit
  localparam int BLINK_TICK_NS   = 100000000;  // 100 ms per blink unit
  localparam int FADE_TICK_CYC   = (FADE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_TICK_CYC  = (BLINK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage : alfb_pkg
`default_nettype wire

/* src/alfb_ctrl.sv */
// Auxiliary LED controller: three sink-current codes with fade and blink.
// Assumes a single AHB-Lite master, single word transfers, one clock.
//
// Implementation choice: register access over AHB-Lite.
`default_nettype none
module alfb_ctrl
  import alfb_pkg::*;
#(
  parameter int FADE_TICK  = alfb_pkg::FADE_TICK_CYC,   // cycles per fade unit
  parameter int BLINK_TICK = alfb_pkg::BLINK_TICK_CYC   // cycles per blink unit
) (
  input  wire  logic        hclk,         // bus clock, 125 MHz
  input  wire  logic        hresetn,      // async reset, active low
  input  wire  logic        hsel,         // slave select
  input  wire  logic [31:0] haddr,        // byte address
  input  wire  logic [1:0]  htrans,       // transfer type
  input  wire  logic        hwrite,       // write when high
  input  wire  logic [2:0]  hsize,        // transfer size
  input  wire  logic [31:0] hwdata,       // write data
  input  wire  logic        hready,       // bus ready in
  output var   logic        hreadyout,    // always ready
  output var   logic        hresp,        // always OKAY
  output var   logic [31:0] hrdata,       // read data
  output var   logic [7:0]  sink_one,     // LED 1 sink-current code
  output var   logic [7:0]  sink_two,     // LED 2 sink-current code
  output var   logic [7:0]  sink_three    // LED 3 sink-current code
);
  import alfb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] main_q, aux_en_q, blink_q, fade_q;
  logic [7:0] cur_q [3];
  logic [8:0] lvl_q [3];
  logic [2:0] phase_on_q;
  logic [7:0] sink_q [3];

  // Byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [7:0] idx);
    reg_addr = {22'h0, idx, 2'b00};
  endfunction

  // Fade profile applied to the ramp level
  function automatic logic [8:0] shape(input logic [8:0] lvl, input logic sq);
    logic [17:0] p;
    p = lvl * lvl;
    shape = sq ? p[16:8] : lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: address phase captured, data phase completes at once
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic        take;
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Zero wait states, so ready and response are constant flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0;
    end else begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_q   <= REG_RESET;
      aux_en_q <= REG_RESET;
      blink_q  <= REG_RESET;
      fade_q   <= REG_RESET;
      cur_q[0] <= REG_RESET;
      cur_q[1] <= REG_RESET;
      cur_q[2] <= REG_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == reg_addr(IDX_MAIN_CONTROL)) begin
        main_q <= hwdata[7:0];
      end else if (wr_addr_q == reg_addr(IDX_AUX_ENABLE)) begin
        aux_en_q <= hwdata[7:0];
      end else if (wr_addr_q == reg_addr(IDX_BLINK_TIMERS)) begin
        blink_q <= hwdata[7:0];
      end else if (wr_addr_q == reg_addr(IDX_FADE_TIMES)) begin
        fade_q <= hwdata[7:0];
      end else if (wr_addr_q == reg_addr(IDX_LED_ONE_SINK)) begin
        cur_q[0] <= hwdata[7:0];
      end else if (wr_addr_q == reg_addr(IDX_LED_TWO_SINK)) begin
        cur_q[1] <= hwdata[7:0];
      end else if (wr_addr_q == reg_addr(IDX_LED_THREE_SINK)) begin
        cur_q[2] <= hwdata[7:0];
      end
    end
  end

  // Read data registered at the address phase, ready in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      if (haddr == reg_addr(IDX_MAIN_CONTROL)) begin
        hrdata <= {24'h0, main_q};
      end else if (haddr == reg_addr(IDX_AUX_ENABLE)) begin
        hrdata <= {24'h0, aux_en_q};
      end else if (haddr == reg_addr(IDX_BLINK_TIMERS)) begin
        hrdata <= {24'h0, blink_q};
      end else if (haddr == reg_addr(IDX_FADE_TIMES)) begin
        hrdata <= {24'h0, fade_q};
      end else if (haddr == reg_addr(IDX_LED_ONE_SINK)) begin
        hrdata <= {24'h0, cur_q[0]};
      end else if (haddr == reg_addr(IDX_LED_TWO_SINK)) begin
        hrdata <= {24'h0, cur_q[1]};
      end else if (haddr == reg_addr(IDX_LED_THREE_SINK)) begin
        hrdata <= {24'h0, cur_q[2]};
      end else if (haddr == reg_addr(IDX_AUX_STATUS)) begin
        // Lit flags, then blink phases
        hrdata <= {26'h0, phase_on_q,
                   lvl_q[2] != 9'h0, lvl_q[1] != 9'h0, lvl_q[0] != 9'h0};
      end else begin
        hrdata <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bases: one-cycle enables from free-running dividers
  logic [31:0] fdiv_q, bdiv_q;
  logic        ftick_q, btick_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fdiv_q  <= 32'h0;
      ftick_q <= 1'b0;
    end else begin
      ftick_q <= (fdiv_q == 32'(FADE_TICK - 1));
      fdiv_q  <= (fdiv_q == 32'(FADE_TICK - 1)) ? 32'h0 : fdiv_q + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bdiv_q  <= 32'h0;
      btick_q <= 1'b0;
    end else begin
      btick_q <= (bdiv_q == 32'(BLINK_TICK - 1));
      bdiv_q  <= (bdiv_q == 32'(BLINK_TICK - 1)) ? 32'h0 : bdiv_q + 32'h1;
    end
  end

  // Step pulses: one level step every fade code units
  logic [3:0] fin_cnt_q, fout_cnt_q;
  logic       in_step_q, out_step_q;
  logic [3:0] fin_code, fout_code;
  assign fin_code  = fade_q[FADE_IN_LSB +: 4];
  assign fout_code = fade_q[FADE_OUT_LSB +: 4];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fin_cnt_q  <= 4'h0;
      fout_cnt_q <= 4'h0;
      in_step_q  <= 1'b0;
      out_step_q <= 1'b0;
    end else begin
      in_step_q  <= 1'b0;
      out_step_q <= 1'b0;
      if (ftick_q) begin
        in_step_q  <= (fin_cnt_q + 4'h1 >= fin_code);
        fin_cnt_q  <= (fin_cnt_q + 4'h1 >= fin_code) ? 4'h0 : fin_cnt_q + 4'h1;
        out_step_q <= (fout_cnt_q + 4'h1 >= fout_code);
        fout_cnt_q <= (fout_cnt_q + 4'h1 >= fout_code) ? 4'h0 : fout_cnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink: shared on time, own off time; code zero means steady on
  logic [1:0] on_code;
  logic [2:0] blink_en;
  logic [2:0] target;
  logic [2:0] bcnt_q [3];
  logic       master;
  assign master  = main_q[MAIN_MASTER_BIT];
  assign on_code = blink_q[BLINK_ON_LSB +: 2];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      blink_en[i] = (on_code != 2'h0) && (blink_q[BLINK_OFF_LSB + 2 * i +: 2] != 2'h0);
      target[i]   = master && aux_en_q[i] && phase_on_q[i];
    end
  end

  // Phase toggles after on or off units elapse; restarts on while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_on_q <= 3'b111;
      for (int i = 0; i < 3; i++) bcnt_q[i] <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!blink_en[i] || !aux_en_q[i] || !master) begin
          phase_on_q[i] <= 1'b1;
          bcnt_q[i]     <= 3'h0;
        end else if (btick_q) begin
          if (bcnt_q[i] + 3'h1 >= (phase_on_q[i] ? {1'b0, on_code}
                                   : {1'b0, blink_q[BLINK_OFF_LSB + 2 * i +: 2]})) begin
            phase_on_q[i] <= !phase_on_q[i];
            bcnt_q[i]     <= 3'h0;
          end else begin
            bcnt_q[i] <= bcnt_q[i] + 3'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp level per LED; fade code zero jumps straight to the target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) lvl_q[i] <= 9'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!master) begin
          lvl_q[i] <= 9'h0;
        end else if (target[i]) begin
          if (fin_code == 4'h0) begin
            lvl_q[i] <= LEVEL_FULL;
          end else if (in_step_q && lvl_q[i] < LEVEL_FULL) begin
            lvl_q[i] <= lvl_q[i] + 9'h1;
          end
        end else begin
          if (fout_code == 4'h0) begin
            lvl_q[i] <= 9'h0;
          end else if (out_step_q && lvl_q[i] != 9'h0) begin
            lvl_q[i] <= lvl_q[i] - 9'h1;
          end
        end
      end
    end
  end

  // Sink code is the LED's current scaled by the shaped level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) sink_q[i] <= 8'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        logic [16:0] prod;
        prod = cur_q[i] * shape(lvl_q[i], aux_en_q[AUX_SQUARE_BIT]);
        sink_q[i] <= master ? prod[15:8] : 8'h0;
      end
    end
  end
  assign sink_one   = sink_q[0];
  assign sink_two   = sink_q[1];
  assign sink_three = sink_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_master_off;
    !main_q[MAIN_MASTER_BIT];
  endsequence
  sequence s_outputs_dark;
    (sink_q[0] == 8'h0) && (sink_q[1] == 8'h0) && (sink_q[2] == 8'h0);
  endsequence

  chk_master_gate_dark: assert property (@(posedge hclk) disable iff (!hresetn)
    s_master_off ##1 s_master_off |=> s_outputs_dark)
    else $error("sink driven while master enable clear");
  chk_disable_no_fade: assert property (@(posedge hclk) disable iff (!hresetn)
    master && !aux_en_q[1] && fout_code == 4'h0 |=> lvl_q[1] == 9'h0)
    else $error("LED two level not zero after disable");
  chk_enable_no_fade: assert property (@(posedge hclk) disable iff (!hresetn)
    target[0] && fin_code == 4'h0 |=> lvl_q[0] == LEVEL_FULL)
    else $error("LED one not at full level");
  chk_fade_in_step: assert property (@(posedge hclk) disable iff (!hresetn)
    target[2] && fin_code != 4'h0 && in_step_q && lvl_q[2] < LEVEL_FULL
      |=> lvl_q[2] == $past(lvl_q[2]) + 9'h1)
    else $error("fade-in step missed");
  chk_fade_out_step: assert property (@(posedge hclk) disable iff (!hresetn)
    master && !target[0] && fout_code != 4'h0 && out_step_q && lvl_q[0] != 9'h0
      |=> lvl_q[0] == $past(lvl_q[0]) - 9'h1)
    else $error("fade-out step missed");
  chk_level_hold_between: assert property (@(posedge hclk) disable iff (!hresetn)
    master && fin_code != 4'h0 && fout_code != 4'h0 && !in_step_q && !out_step_q
      |=> $stable(lvl_q[1]))
    else $error("level moved without a step");
  chk_linear_full_current: assert property (@(posedge hclk) disable iff (!hresetn)
    master && lvl_q[2] == LEVEL_FULL && !aux_en_q[AUX_SQUARE_BIT] |=> sink_q[2] == $past(cur_q[2]))
    else $error("full level does not give programmed current");
  // Half ramp under square law gives a quarter of the current; LED 3 is the one the bench fades
  chk_square_half_level: assert property (@(posedge hclk) disable iff (!hresetn)
    master && lvl_q[2] == 9'h080 && aux_en_q[AUX_SQUARE_BIT] && cur_q[2] == 8'hc8 |=> sink_q[2] == 8'h32)
    else $error("square profile wrong at half level");
  chk_blink_on_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    blink_en[1] && aux_en_q[1] && master && $past(blink_en[1] && aux_en_q[1] && master)
      && $changed(phase_on_q[1]) |-> $past(btick_q))
    else $error("blink phase changed off the blink tick");
  chk_bus_always_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule : alfb_ctrl
`default_nettype wire

/* sim/alfb_led_model.sv */
// Behavioural model of the three auxiliary LEDs on their current sinks.
// Assumes the bench pulses clr_cnt to start each measurement window.
`default_nettype none
module alfb_led_model (
  input  wire logic        hclk,       // bus clock
  input  wire logic [7:0]  sink_one,   // LED 1 current code
  input  wire logic [7:0]  sink_two,   // LED 2 current code
  input  wire logic [7:0]  sink_three, // LED 3 current code
  input  wire logic        clr_cnt,    // restart counters
  output var  logic [15:0] lit_one,    // cycles LED 1 lit
  output var  logic [15:0] lit_two,    // cycles LED 2 lit
  output var  logic [15:0] lit_three,  // cycles LED 3 lit
  output var  logic [7:0]  peak_one    // highest code on LED 1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Any nonzero code lights the LED; peak shows whether a ramp got to the top
  always @(posedge hclk) begin
    if (clr_cnt) begin
      lit_one <= 16'h0000;
      lit_two <= 16'h0000;
      lit_three <= 16'h0000;
      peak_one <= 8'h00;
    end else begin
      lit_one <= lit_one + 16'(sink_one != 8'h00);
      lit_two <= lit_two + 16'(sink_two != 8'h00);
      lit_three <= lit_three + 16'(sink_three != 8'h00);
      if (sink_one > peak_one) peak_one <= sink_one;
    end
  end
endmodule // alfb_led_model
`default_nettype wire

/* sim/alfb_tb.sv */
// Self-checking bench: AHB-Lite register tasks, LED model on the sinks.
// Assumes short fade and blink tick parameters so ramps last ~1000 cycles.
`default_nettype none
module testbench;
  import alfb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, clr_cnt;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  sink_one, sink_two, sink_three, peak_one;
  logic [15:0] lit_one, lit_two, lit_three;
  int          err_total, checks;
  localparam logic [7:0] IDX_TAB [8] = '{IDX_MAIN_CONTROL, IDX_AUX_ENABLE, IDX_BLINK_TIMERS,
    IDX_FADE_TIMES, IDX_LED_ONE_SINK, IDX_LED_TWO_SINK, IDX_LED_THREE_SINK, 8'h3f};
  localparam logic [7:0] CUR [3] = '{8'h30, 8'h60, 8'hc8};
  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and LED model
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  alfb_ctrl #(.FADE_TICK(4), .BLINK_TICK(16)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .sink_one(sink_one), .sink_two(sink_two),
    .sink_three(sink_three));
  alfb_led_model led (
    .hclk(hclk), .sink_one(sink_one), .sink_two(sink_two), .sink_three(sink_three),
    .clr_cnt(clr_cnt), .lit_one(lit_one), .lit_two(lit_two), .lit_three(lit_three),
    .peak_one(peak_one));
  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks: address phase held until hready, then data phase
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] val);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, val};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    xfer(1'b1, idx, val);
  endtask
  // Sinks settle two edges after the register update
  task automatic wrs(input logic [7:0] idx, input logic [7:0] val);
    xfer(1'b1, idx, val);
    repeat (3) @(posedge hclk);
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // Ramps and duty cycles are judged within a window, not to the cycle
  task automatic rng(input string what, input int lo, input int hi, input logic [15:0] got);
    checks++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      err_total++;
      $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask
  task automatic sinks(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    cmp("sink_one", {24'h0, a}, {24'h0, sink_one});
    cmp("sink_two", {24'h0, b}, {24'h0, sink_two});
    cmp("sink_three", {24'h0, c}, {24'h0, sink_three});
  endtask
  task automatic test_done;
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the ~6500 cycles of the sequence
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0; hresetn = 1'b0; clr_cnt = 1'b0; err_total = 0; checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped place reads zero
    foreach (IDX_TAB[i]) begin
      xfer(1'b0, IDX_TAB[i], 8'h00);
      cmp("reset value", {24'h0, REG_RESET}, d);
    end
    // Status after reset: all dark, every blink phase parked in on
    xfer(1'b0, IDX_AUX_STATUS, 8'h00);
    cmp("status reset", 32'h38, d);
    cmp("hresp", 32'h0, {31'h0, hresp});
    foreach (CUR[i]) begin
      wr(IDX_LED_ONE_SINK + 8'(i), CUR[i]);
      xfer(1'b0, IDX_LED_ONE_SINK + 8'(i), 8'h00);
      cmp("current reg", {24'h0, CUR[i]}, d);
    end
    wr(8'h3f, 8'hff);
    xfer(1'b0, 8'h3f, 8'h00);
    cmp("unmapped", 32'h0, d);
    // Enables without master, then master on, one LED off, master off
    wrs(IDX_AUX_ENABLE, 8'h07);
    sinks(8'h00, 8'h00, 8'h00);
    wrs(IDX_MAIN_CONTROL, 8'h80);
    sinks(CUR[0], CUR[1], CUR[2]);
    wrs(IDX_AUX_ENABLE, 8'h05);
    sinks(CUR[0], 8'h00, CUR[2]);
    wrs(IDX_MAIN_CONTROL, 8'h00);
    sinks(8'h00, 8'h00, 8'h00);
    // Fade on LED 3, linear then square law, 1024-cycle ramps
    wr(IDX_AUX_ENABLE, 8'h00);
    wr(IDX_MAIN_CONTROL, 8'h80);
    wr(IDX_FADE_TIMES, 8'h11);
    xfer(1'b0, IDX_FADE_TIMES, 8'h00);
    cmp("fade reg", 32'h11, d);
    for (int sq = 0; sq < 2; sq++) begin
      wr(IDX_AUX_ENABLE, sq ? 8'h0c : 8'h04);
      repeat (512) @(posedge hclk);
      rng("fade in mid", sq ? 30 : 70, sq ? 70 : 130, {8'h00, sink_three});
      repeat (600) @(posedge hclk);
      cmp("fade in end", {24'h0, CUR[2]}, {24'h0, sink_three});
      wr(IDX_AUX_ENABLE, sq ? 8'h08 : 8'h00);
      repeat (512) @(posedge hclk);
      rng("fade out mid", sq ? 30 : 70, sq ? 70 : 130, {8'h00, sink_three});
      repeat (600) @(posedge hclk);
      cmp("fade out end", 32'h0, {24'h0, sink_three});
    end
    // Blink: on 1 unit, LED1 off 1, LED2 off 2, LED3 steady
    wr(IDX_FADE_TIMES, 8'h00);
    wr(IDX_BLINK_TIMERS, 8'h25);
    wr(IDX_AUX_ENABLE, 8'h07);
    repeat (40) @(posedge hclk);
    clr_cnt <= 1'b1;
    @(posedge hclk);
    clr_cnt <= 1'b0;
    repeat (480) @(posedge hclk);
    // Counters update on the edge itself; look once they have settled
    @(negedge hclk);
    rng("blink one", 220, 260, lit_one);
    rng("blink two", 140, 180, lit_two);
    cmp("blink three", 32'd480, {16'h0, lit_three});
    @(posedge hclk);
    // Blink with fade: on 3 units, LED1 off 1; ramp climbs but never reaches the top
    wr(IDX_AUX_ENABLE, 8'h00);
    wr(IDX_FADE_TIMES, 8'h11);
    wr(IDX_BLINK_TIMERS, 8'h27);
    repeat (1100) @(posedge hclk);
    clr_cnt <= 1'b1;
    @(posedge hclk);
    clr_cnt <= 1'b0;
    wr(IDX_AUX_ENABLE, 8'h01);
    repeat (300) @(posedge hclk);
    rng("blink fade peak", 1, 47, {8'h00, peak_one});
    wrs(IDX_MAIN_CONTROL, 8'h00);
    sinks(8'h00, 8'h00, 8'h00);
    test_done();
  end
endmodule // testbench
`default_nettype wire
